//--- logic/tcq_capture.sv
// trace capture qualifier: picks cpu activity for the trace buffer
`timescale 1ns/100ps
`default_nettype none
`include "tcq_cfg.svh"
module tcq_capture
  import tcq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic arm,
  input wire logic final_state,
  input wire logic trig_on_flow,
  input wire tcq_cpu_ev_t cpu_ev,
  output logic armed,
  output logic disarm,
  output logic buf_we,
  output logic [19:0] buf_wdata,
  output logic [6:0] trace_line_counter
);
  // ------------------------------------------------------------------
  // register port
  // ------------------------------------------------------------------
  logic [3:0] ctrl_q;
  logic [3:0] ctrl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic trace_source_enable;
  logic trigger_alignment_select;
  logic [1:0] trace_mode_select;
  tcq_mode_t mode;
  logic armed_q;
  logic [6:0] cnt_q;
  assign trace_source_enable = ctrl_q[`TCQ_BIT_ENABLE];
  assign trigger_alignment_select = ctrl_q[`TCQ_BIT_ALIGN];
  assign trace_mode_select = ctrl_q[`TCQ_BIT_MODE_LO +: 2];
  // all four codes are used, so no leftover maps elsewhere
  assign mode = tcq_mode_t'(trace_mode_select); // RULE3 RULE25
  assign ctrl_d = (reg_wr && reg_addr == `TCQ_ADDR_CTRL)
    ? reg_wdata[3:0] : ctrl_q;
  assign rdata_d = !reg_rd ? 8'h00
    : (reg_addr == `TCQ_ADDR_CTRL) ? {4'h0, ctrl_q}
    : (reg_addr == `TCQ_ADDR_CNT) ? {1'b0, cnt_q}
    : (reg_addr == `TCQ_ADDR_STAT) ? {7'h00, armed_q}
    : 8'h00;
  assign reg_rdata = rdata_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `TCQ_CTRL_RST;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end
  // ------------------------------------------------------------------
  // arming
  // ------------------------------------------------------------------
  logic end_hit;
  assign end_hit = armed_q && final_state && !trigger_alignment_select;
  assign disarm = end_hit; // RULE1
  assign armed = armed_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (end_hit) begin
      armed_q <= 1'b0; // RULE1
    end else if (arm) begin
      armed_q <= 1'b1;
    end
  end
  // ------------------------------------------------------------------
  // event selection
  // ------------------------------------------------------------------
  logic [17:0] last_q;
  logic last_vld_q;
  logic cap_ok;
  logic is_src;
  logic is_dst;
  logic is_vec;
  logic dup_src;
  logic flow_pick;
  logic detail_pick;
  logic pc_pick;
  logic busy;
  logic store_flow;
  logic store_detail;
  logic [19:0] flow_line;
  logic [19:0] det_addr_line;
  logic [19:0] det_data_line;
  logic is_flow_mode;
  // trigger event itself is dropped on end-aligned flow change
  assign cap_ok = trace_source_enable && armed_q // RULE4
    && !(end_hit && trig_on_flow); // RULE2
  // direct jumps and plain branches never raise these strobes
  assign is_src = cpu_ev.br_taken; // RULE5 RULE9
  assign is_dst = cpu_ev.dst_done; // RULE6 RULE7 RULE11
  assign is_vec = cpu_ev.vec && !cpu_ev.bgnd_vec; // RULE8
  assign is_flow_mode = (mode == TCQ_NORMAL) || (mode == TCQ_LOOP);
  // the compare updates at the edge after a store, so a refetch in the next cycle is already dropped
  assign dup_src = (mode == TCQ_LOOP) && is_src && !is_dst && !is_vec
    && last_vld_q && (last_q == cpu_ev.addr); // RULE13 RULE14 RULE15
  assign flow_pick = is_flow_mode && (is_src || is_dst || is_vec)
    && !dup_src;
  assign detail_pick = (mode == TCQ_DETAIL) && cpu_ev.access
    && !cpu_ev.free_cyc && !cpu_ev.fetch_cyc; // RULE16 RULE18
  assign pc_pick = (mode == TCQ_PUREPC) && cpu_ev.opcode_exec; // RULE19
  assign store_flow = cap_ok && (flow_pick || pc_pick);
  assign store_detail = cap_ok && detail_pick && !busy;
  // vector implies destination flag
  assign flow_line = {
    (is_dst || is_vec) && !is_src && (mode != TCQ_PUREPC),
    is_vec && (mode != TCQ_PUREPC),
    cpu_ev.addr}; // RULE10 RULE23
  assign det_addr_line = {cpu_ev.byte_acc, cpu_ev.rd,
    cpu_ev.addr}; // RULE17 RULE22
  // byte data sits in the low byte with the high byte cleared
  assign det_data_line = {4'h0,
    cpu_ev.byte_acc ? 8'h00 : cpu_ev.data[15:8],
    cpu_ev.data[7:0]};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 18'h00000;
      last_vld_q <= 1'b0;
    end else if (arm && !armed_q) begin
      last_vld_q <= 1'b0; // RULE26
    end else if (store_flow && mode == TCQ_LOOP) begin
      last_q <= cpu_ev.addr; // RULE12
      last_vld_q <= 1'b1;
    end
  end
  // ------------------------------------------------------------------
  // buffer write and line counter
  // ------------------------------------------------------------------
  tcq_line_t det_out;
  logic we_q;
  logic [19:0] wd_q;
  tcq_detail_split u_split (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(store_detail),
    .addr_line(det_addr_line),
    .data_line(det_data_line),
    .busy(busy),
    .out(det_out)
  );
  assign buf_we = we_q | det_out.valid;
  assign buf_wdata = det_out.valid ? det_out.line : wd_q;
  assign trace_line_counter = cnt_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      we_q <= 1'b0;
      wd_q <= 20'h00000;
      cnt_q <= 7'h00;
    end else begin
      we_q <= store_flow;
      wd_q <= flow_line;
      if (arm && !armed_q) begin
        cnt_q <= 7'h00;
      end else if (buf_we) begin
        cnt_q <= cnt_q + 7'h01; // RULE24
      end
    end
  end
  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_noen;
    @(posedge clk_sys) disable iff (!rst_n)
      !trace_source_enable |-> !store_flow && !store_detail;
  endproperty
  a_noen: assert property (p_noen) else $error("store while off"); // RULE4
  property p_cnt;
    @(posedge clk_sys) disable iff (!rst_n)
      buf_we && !(arm && !armed_q) |=> cnt_q == $past(cnt_q) + 7'h01;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count miss"); // RULE24
  property p_two;
    @(posedge clk_sys) disable iff (!rst_n)
      store_detail |=> det_out.valid ##1 det_out.valid;
  endproperty
  a_two: assert property (p_two) else $error("detail lines"); // RULE21
  property p_disarm;
    @(posedge clk_sys) disable iff (!rst_n)
      end_hit |=> !armed_q;
  endproperty
  a_disarm: assert property (p_disarm) else $error("no disarm"); // RULE1
  property p_vec;
    @(posedge clk_sys) disable iff (!rst_n)
      we_q && wd_q[18] |-> wd_q[19];
  endproperty
  a_vec: assert property (p_vec) else $error("vector flag"); // RULE23
  property p_dup;
    @(posedge clk_sys) disable iff (!rst_n)
      dup_src |-> !store_flow;
  endproperty
  a_dup: assert property (p_dup) else $error("dup stored"); // RULE13
  property p_fetch;
    @(posedge clk_sys) disable iff (!rst_n)
      cpu_ev.fetch_cyc || cpu_ev.free_cyc |-> !store_detail;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch stored"); // RULE18
  property p_trig;
    @(posedge clk_sys) disable iff (!rst_n)
      end_hit && trig_on_flow |=> !we_q;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger stored"); // RULE2
endmodule : tcq_capture
`default_nettype wire

//--- logic/tcq_cfg.svh
// constants for the trace capture qualifier
// Notes on behaviour
// RULE1: end trigger: trace until final, then disarm
// RULE2: end trigger on flow change: not stored
// RULE3: four trace modes chosen by mode field
// RULE4: capture only while source enable set
// RULE5: normal: store source of taken branches
// RULE6: normal: store indexed jump/call destinations
// RULE7: normal: store return destinations
// RULE8: normal: store vectors except background vectors
// RULE9: plain branches and direct jumps never stored
// RULE10: entry holds full address plus info bits
// RULE11: destination stored at completion despite interrupt
// RULE12: loop filter: copy stored address to compare
// RULE13: loop filter: drop repeated source only
// RULE14: loop filter: destinations and vectors always kept
// RULE15: tight loops may store source twice
// RULE16: detail: store address and data of accesses
// RULE17: detail: info bits give size and direction
// RULE18: detail: skip free and opcode fetch cycles
// RULE19: pure pc: store every executed opcode address
// RULE20: debugger prefers tagged breakpoints to end
// RULE21: detail: address line then data line
// RULE22: size 0 word 1 byte; dir 0 write
// RULE23: vector flag implies destination flag
// RULE24: line counter increments per buffer write
// RULE25: one code per mode, rest as normal
// RULE26: compare register cleared on arm
`ifndef TCQ_CFG_SVH
`define TCQ_CFG_SVH
`define TCQ_ADDR_W 18
`define TCQ_LINE_W 20
`define TCQ_CNT_W 7
`define TCQ_MODE_NORMAL 2'h0
`define TCQ_MODE_LOOP 2'h1
`define TCQ_MODE_DETAIL 2'h2
`define TCQ_MODE_PUREPC 2'h3
`define TCQ_CTRL_RST 4'h0
`define TCQ_ADDR_CTRL 2'h0
`define TCQ_ADDR_CNT 2'h1
`define TCQ_ADDR_STAT 2'h2
`define TCQ_BIT_ENABLE 0
`define TCQ_BIT_ALIGN 1
`define TCQ_BIT_MODE_LO 2
`define TCQ_FLAG_SET 1'b1
`define TCQ_FLAG_CLR 1'b0
`endif

//--- logic/tcq_pkg.sv
// types for the trace capture qualifier
package tcq_pkg;
  typedef enum logic [1:0] {
    TCQ_NORMAL,
    TCQ_LOOP,
    TCQ_DETAIL,
    TCQ_PUREPC
  } tcq_mode_t;
  // one observed cpu event, sampled on the bus clock
  typedef struct packed {
    logic [17:0] addr;
    logic [15:0] data;
    logic br_taken;    // taken conditional branch, addr is source
    logic dst_done;    // indexed jump/call or return completed
    logic vec;         // interrupt vector fetch
    logic bgnd_vec;    // vector belongs to background mode
    logic opcode_exec; // opcode executed, addr is its pc
    logic access;      // memory or register access
    logic free_cyc;
    logic fetch_cyc;
    logic byte_acc;
    logic rd;
  } tcq_cpu_ev_t;
  typedef struct packed {
    logic valid;
    logic [19:0] line;
  } tcq_line_t;
endpackage : tcq_pkg

//--- logic/tcq_detail_split.sv
// splits one detail entry into an address line and a data line
`timescale 1ns/100ps
`default_nettype none
`include "tcq_cfg.svh"
module tcq_detail_split
  import tcq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [19:0] addr_line,
  input wire logic [19:0] data_line,
  output logic busy,
  output tcq_line_t out
);
  logic pend_q;
  logic [19:0] data_q;
  tcq_line_t out_q;
  assign busy = pend_q;
  assign out = out_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      data_q <= 20'h00000;
      out_q <= '0;
    end else begin
      out_q.valid <= start | pend_q;
      out_q.line <= pend_q ? data_q : addr_line; // RULE21
      pend_q <= start;
      if (start) begin
        data_q <= data_line;
      end
    end
  end
endmodule : tcq_detail_split
`default_nettype wire

//--- verification/tcq_cpu_model.sv
// cpu pipeline model: turns one request into one observed bus event
`timescale 1ns/100ps
`default_nettype none
module tcq_cpu_model
  import tcq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [17:0] addr,
  input wire logic [15:0] data,
  output tcq_cpu_ev_t ev
);
  tcq_cpu_ev_t ev_d;
  always_comb begin
    ev_d = '0;
    // idle bus shows inverted lines so a stale value never looks valid
    ev_d.addr = ~ev.addr;
    ev_d.data = ~ev.data;
    if (go) begin
      ev_d.addr = addr;
      ev_d.data = data;
      ev_d.br_taken = kind == 3'h0;
      ev_d.dst_done = kind == 3'h1;
      ev_d.vec = kind inside {3'h2, 3'h3};
      ev_d.bgnd_vec = kind == 3'h3;
      ev_d.opcode_exec = kind == 3'h4;
      ev_d.access = kind inside {3'h5, 3'h6, 3'h7};
      ev_d.fetch_cyc = kind == 3'h7;
      ev_d.rd = kind == 3'h6;
      ev_d.byte_acc = kind == 3'h6;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      ev <= '0;
    else
      ev <= ev_d;
  end
endmodule : tcq_cpu_model
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the trace capture qualifier
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tcq_pkg::*;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_rdata;
  logic arm = 1'h0;
  logic final_state = 1'h0;
  logic trig_on_flow = 1'h0;
  logic go = 1'h0;
  logic [2:0] kind = 3'h0;
  logic [17:0] ev_addr = 18'h00000;
  logic [15:0] ev_data = 16'h0000;
  tcq_cpu_ev_t cpu_ev;
  logic armed;
  logic disarm;
  logic buf_we;
  logic [19:0] buf_wdata;
  logic [6:0] trace_line_counter;
  logic [19:0] q[$];
  logic [19:0] ex[$];
  logic [19:0] msk = 20'hfffff;
  logic seen_disarm = 1'h0;
  int error_cnt = 0;
  int checks = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (buf_we)
      q.push_back(buf_wdata);
    if (disarm === 1'h1)
      seen_disarm <= 1'h1;
  end
  tcq_cpu_model cpu (.clk_sys(clk_sys), .rst_n(rst_n), .go(go),
    .kind(kind), .addr(ev_addr), .data(ev_data), .ev(cpu_ev));
  tcq_capture dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arm(arm),
    .final_state(final_state), .trig_on_flow(trig_on_flow),
    .cpu_ev(cpu_ev), .armed(armed), .disarm(disarm), .buf_we(buf_we),
    .buf_wdata(buf_wdata), .trace_line_counter(trace_line_counter));
  // ----
  // tasks
  // ----
  task automatic complete_run();
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [19:0] e,
                     input logic [19:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 chk("reg_rdata", {12'h000, e}, {12'h000, reg_rdata});
  endtask : rd
  // one event, then idle cycles so the detail split is never busy for the next one
  task automatic send(input logic [2:0] k, input logic [17:0] a,
                      input logic [15:0] d);
    @(posedge clk_sys);
    go <= 1'h1;
    kind <= k;
    ev_addr <= a;
    ev_data <= d;
    @(posedge clk_sys);
    go <= 1'h0;
    repeat (3) @(posedge clk_sys);
  endtask : send
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    chk("line count", 20'(ex.size()), 20'(q.size()));
    foreach (ex[i])
      if (i < q.size())
        chk("trace line", ex[i] & msk, q[i] & msk);
    ex.delete();
    q.delete();
  endtask : settle
  task automatic pulse_arm();
    @(posedge clk_sys);
    arm <= 1'h1;
    @(posedge clk_sys);
    arm <= 1'h0;
  endtask : pulse_arm
  // ----
  // sequence
  // ----
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h3, 8'h00);
    pulse_arm();
    rd(2'h2, 8'h01);
    chk("armed", 20'h1, {19'h0, armed});
    wr(2'h0, 8'h01);
    send(3'h0, 18'h2a5c3, 16'h0000);
    ex.push_back({2'h0, 18'h2a5c3});
    send(3'h1, 18'h1f00e, 16'h0000);
    ex.push_back({2'h2, 18'h1f00e});
    send(3'h2, 18'h3fff2, 16'h0000);
    ex.push_back({2'h3, 18'h3fff2});
    send(3'h3, 18'h3fff6, 16'h0000);
    send(3'h4, 18'h00400, 16'h0000);
    send(3'h5, 18'h00800, 16'h0000);
    settle();
    rd(2'h1, 8'h03);
    chk("counter", 20'h3, {13'h0, trace_line_counter});
    wr(2'h0, 8'h00);
    send(3'h0, 18'h2a5c3, 16'h0000);
    settle();
    wr(2'h0, 8'h05);
    send(3'h0, 18'h10000, 16'h0000);
    send(3'h0, 18'h10000, 16'h0000);
    send(3'h1, 18'h1f00e, 16'h0000);
    send(3'h1, 18'h1f00e, 16'h0000);
    send(3'h2, 18'h3fff2, 16'h0000);
    send(3'h2, 18'h3fff2, 16'h0000);
    send(3'h0, 18'h10000, 16'h0000);
    ex = '{20'h10000, 20'h9f00e, 20'h9f00e, 20'hffff2, 20'hffff2, 20'h10000};
    settle();
    wr(2'h0, 8'h09);
    send(3'h5, 18'h2a5c3, 16'h1234);
    send(3'h6, 18'h1f00e, 16'h56ab);
    send(3'h7, 18'h00900, 16'h4321);
    send(3'h0, 18'h00a00, 16'h0000);
    ex = '{20'h2a5c3, 20'h01234, 20'hdf00e, 20'h000ab};
    settle();
    rd(2'h1, 8'h0d);
    wr(2'h0, 8'h0d);
    msk = 20'h3ffff;
    send(3'h4, 18'h30123, 16'h0000);
    send(3'h4, 18'h30123, 16'h0000);
    ex = '{20'h30123, 20'h30123};
    settle();
    msk = 20'hfffff;
    wr(2'h0, 8'h01);
    @(posedge clk_sys);
    go <= 1'h1;
    kind <= 3'h0;
    ev_addr <= 18'h2a5c3;
    @(posedge clk_sys);
    go <= 1'h0;
    // session ends at the sequencer's final state, not a forced break
    final_state <= 1'h1;
    trig_on_flow <= 1'h1;
    @(posedge clk_sys);
    final_state <= 1'h0;
    trig_on_flow <= 1'h0;
    send(3'h0, 18'h2a5c3, 16'h0000);
    settle();
    chk("disarm seen", 20'h1, {19'h0, seen_disarm});
    rd(2'h2, 8'h00);
    chk("armed off", 20'h0, {19'h0, armed});
    pulse_arm();
    wr(2'h0, 8'h05);
    send(3'h0, 18'h10000, 16'h0000);
    ex.push_back(20'h10000);
    settle();
    rd(2'h1, 8'h01);
    complete_run();
  end
endmodule : tb
`default_nettype wire
